// [common/ccp_pkg.sv]
// Purpose: constants and carrier types for the coil current PWM output group
// Assumes: one 250 MHz clock; measured current arrives as mA counts from a converter
// Notes: ramp times are in 0.01 s units; gains are plain 8-bit unsigned
package ccp_pkg;
  localparam int unsigned CCP_CLK_HZ = 250_000_000;
  // Control period, one ramp step and one regulation update
  localparam int unsigned CCP_PERIOD_US = 100;
  localparam int unsigned CCP_PERIOD_CYC = CCP_CLK_HZ / 1_000_000 * CCP_PERIOD_US;
  // Ramp time unit is 0.01 s, i.e. 100 control periods
  localparam int unsigned CCP_RAMP_UNIT_MS = 10;
  localparam int unsigned CCP_STEPS_PER_UNIT = CCP_RAMP_UNIT_MS * 1000 / CCP_PERIOD_US;
  localparam logic [15:0] CCP_CUR_MAX_MA = 16'h0dac; // 3500 mA span top
  localparam logic [9:0] CCP_DUTY_MAX = 10'h3ff;
  localparam logic [15:0] CCP_SUM_MAX = 16'hffff;
  localparam logic [6:0] CCP_PCT_MAX = 7'h64;
  localparam int unsigned CCP_DUTY_SHIFT = 4;
  localparam logic [7:0] CCP_OPEN_DUTY_MIN = 8'h80; // Duty above which a current below 20 mA means open
  localparam logic [15:0] CCP_OPEN_CUR_MA = 16'h0014;
  localparam logic [15:0] CCP_SHORT_CUR_MA = 16'h0fa0;

  typedef enum logic [1:0] {
    CCP_DUAL_HS = 2'b00,
    CCP_SINGLE_HS = 2'b01,
    CCP_SINGLE_LS = 2'b10
  } ccp_mode_e;

  typedef struct packed {
    logic [15:0] floor_ma;
    logic [15:0] ceiling_ma;
  } ccp_limits_s;

  typedef struct packed {
    logic [15:0] ramp_up;
    logic [15:0] ramp_down;
    logic [7:0] proportional_gain;
    logic [7:0] integral_gain;
  } ccp_tuning_s;

  typedef struct packed {
    logic short_flag;
    logic open_flag;
  } ccp_fault_s;
endpackage

// [rtl/ccp_output.sv]
// Purpose: current-regulated PWM coil output group with ramp, PI loop and fault flags
// Assumes: measured current and fault comparator levels are asynchronous to sys_clk
// Notes: coil 0 is the odd high-side or the low-side coil, coil 1 the even high-side coil
//        ramp rates are full scale per ramp time, not the configured span
`timescale 1ns/100ps
module ccp_output
  import ccp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Configuration
  input wire ccp_mode_e mode,
  input wire logic output_enable,
  input wire logic direction_even,
  input wire logic companion_onoff_coil,
  input wire logic open_detect_inhibit,
  input wire logic [6:0] target_pct,
  input wire ccp_limits_s first_coil_limits,
  input wire ccp_limits_s second_coil_limits,
  input wire ccp_tuning_s tuning,
  // Coil sensing
  input wire logic [15:0] measured_ma,
  input wire logic [1:0] short_sense,
  // Coil drive
  output logic [1:0] coil_pwm,
  output logic [9:0] duty,
  // Status
  output logic [15:0] ramped_setpoint,
  output logic [15:0] regulation_error,
  output logic [15:0] error_integral,
  output ccp_fault_s [1:0] coil_fault
);

  typedef struct packed {
    logic [15:0] meas_s1;
    logic [15:0] meas_s2;
    logic [1:0] short_s1;
    logic [1:0] short_s2;
    logic [15:0] tick_cnt;
    logic [15:0] step_cnt;
    logic [31:0] ramp_acc;
    logic [15:0] setpoint;
    logic [15:0] err;
    logic [15:0] sum;
    logic [9:0] duty;
    logic [9:0] pwm_cnt;
    logic [1:0] pwm;
    ccp_fault_s [1:0] fault;
  } ccp_state_s;

  ccp_state_s st_q;
  ccp_state_s st_d;

  // Target mapping helpers
  logic [6:0] pct_clamped;
  logic [15:0] floor_ma;
  logic [15:0] ceil_ma;
  logic [15:0] target_ma;
  logic [15:0] span_ma;
  logic [22:0] scaled;
  // Ramp accumulator helpers, 16.16 fixed point
  logic [31:0] acc_target;
  logic [31:0] span_step;
  // Regulation helpers, sized so that no product or sum wraps
  logic signed [16:0] err_wide;
  logic signed [17:0] sum_wide;
  logic signed [27:0] p_term;
  logic signed [27:0] i_term;
  logic signed [27:0] pi_sum;
  // Carrier and steering helpers
  logic tick;
  logic pwm_on;
  logic [1:0] driven;

  // ****************************************************************
  // Target mapping
  // ****************************************************************
  // Second coil limits apply only when dual mode steers to the even coil
  always_comb begin
    floor_ma = first_coil_limits.floor_ma;
    ceil_ma = first_coil_limits.ceiling_ma;
    if (mode == CCP_DUAL_HS && direction_even) begin
      floor_ma = second_coil_limits.floor_ma;
      ceil_ma = second_coil_limits.ceiling_ma;
    end
    // A reversed limit pair gives zero span rather than a wrapped one
    span_ma = (ceil_ma > floor_ma) ? ceil_ma - floor_ma : 16'h0000;
    // Targets above full scale are taken as full scale
    pct_clamped = (target_pct > CCP_PCT_MAX) ? CCP_PCT_MAX : target_pct;
    // Widen before the product: span times percent needs up to 23 bits
    scaled = (23'(span_ma) * 23'(pct_clamped)) / 23'(CCP_PCT_MAX);
    // Zero percent means no current at all, not the floor
    target_ma = (pct_clamped == 7'h00) ? 16'h0000 : 16'(floor_ma + scaled[15:0]);
    // Never ask for more than the 3.5 A span, whatever the limits say
    if (target_ma > CCP_CUR_MAX_MA) begin
      target_ma = CCP_CUR_MAX_MA;
    end
  end

  // ****************************************************************
  // Control loop next state
  // ****************************************************************
  // Ramp in a 16.16 accumulator so slow ramps still move by fractions
  always_comb begin
    st_d = st_q;
    // Two-stage synchronisers; a word caught mid-change costs one bad sample only
    st_d.meas_s1 = measured_ma;
    st_d.meas_s2 = st_q.meas_s1;
    st_d.short_s1 = short_sense;
    st_d.short_s2 = st_q.short_s1;
    // Control period divider, one tick per regulation update
    tick = (st_q.tick_cnt == 16'(CCP_PERIOD_CYC - 1));
    st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;
    acc_target = {target_ma, 16'h0000};
    span_step = 32'h0000_0000;
    err_wide = 17'sd0;
    sum_wide = 18'sd0;
    p_term = 28'sd0;
    i_term = 28'sd0;
    pi_sum = 28'sd0;
    if (tick) begin
      // Full-scale step per period is 3500 mA divided by ramp time in periods
      // A zero ramp time jumps straight to the target
      if (acc_target > st_q.ramp_acc) begin
        span_step = (tuning.ramp_up == 16'h0000) ? 32'hffff_ffff :
          {CCP_CUR_MAX_MA, 16'h0000} / (32'(tuning.ramp_up) * 32'(CCP_STEPS_PER_UNIT));
        st_d.ramp_acc = (acc_target - st_q.ramp_acc > span_step) ?
          st_q.ramp_acc + span_step : acc_target;
      end else if (acc_target < st_q.ramp_acc) begin
        // The fall has its own rate so a valve can close faster than it opens
        span_step = (tuning.ramp_down == 16'h0000) ? 32'hffff_ffff :
          {CCP_CUR_MAX_MA, 16'h0000} / (32'(tuning.ramp_down) * 32'(CCP_STEPS_PER_UNIT));
        st_d.ramp_acc = (st_q.ramp_acc - acc_target > span_step) ?
          st_q.ramp_acc - span_step : acc_target;
      end
      st_d.setpoint = st_d.ramp_acc[31:16];
      // Error is taken against the new setpoint so the loop sees the ramp without delay
      err_wide = $signed({1'b0, st_d.setpoint}) - $signed({1'b0, st_q.meas_s2});
      st_d.err = (err_wide > 17'sd32767) ? 16'h7fff :
        (err_wide < -17'sd32768) ? 16'h8000 : err_wide[15:0];
      // Integral saturates instead of wrapping, which bounds the wind-up
      sum_wide = $signed({2'b00, st_q.sum}) + 18'($signed(st_d.err));
      st_d.sum = (sum_wide < 18'sd0) ? 16'h0000 :
        (sum_wide > $signed({2'b00, CCP_SUM_MAX})) ? CCP_SUM_MAX : sum_wide[15:0];
      // Each operand is widened first so the products keep all their bits
      p_term = 28'($signed({1'b0, tuning.proportional_gain})) * 28'($signed(st_d.err));
      i_term = 28'($signed({1'b0, tuning.integral_gain})) * 28'($signed({1'b0, st_d.sum}));
      pi_sum = p_term + i_term;
      pi_sum = pi_sum >>> CCP_DUTY_SHIFT;
      // Negative demand cannot be driven, a single-ended coil only pulls one way
      st_d.duty = (pi_sum < 28'sd0) ? 10'h000 :
        (pi_sum > $signed(28'(CCP_DUTY_MAX))) ? CCP_DUTY_MAX : pi_sum[9:0];
    end
    // Disable acts at once rather than at the next tick, so no stale duty is reported
    // and the integral cannot wind up while the coil is off
    if (!output_enable) begin
      st_d.duty = 10'h000;
      st_d.sum = 16'h0000;
    end
    // PWM carrier of 1024 cycles, duty 0x3ff is fully on
    // The enable gate acts on the carrier directly so carrier drive stops one edge after enable drops; the single high-side companion coil is not gated
    st_d.pwm_cnt = st_q.pwm_cnt + 10'h001;
    pwm_on = output_enable && (st_q.duty != 10'h000) &&
      (st_q.pwm_cnt < st_q.duty || st_q.duty == CCP_DUTY_MAX);
    // Steering: which coil gets the carrier and which coils are judged for faults
    driven = 2'b01;
    st_d.pwm = 2'b00;
    case (mode)
      CCP_DUAL_HS: begin
        driven = direction_even ? 2'b10 : 2'b01;
        st_d.pwm = direction_even ? {pwm_on, 1'b0} : {1'b0, pwm_on};
      end
      CCP_SINGLE_HS: begin
        driven = {companion_onoff_coil, 1'b1};
        st_d.pwm = {companion_onoff_coil, pwm_on};
      end
      // Low-side: one coil only
      default: begin
        st_d.pwm = {1'b0, pwm_on};
      end
    endcase
    // Faults follow the coil while it is driven and clear when it is healthy again
    // An undriven coil keeps its last flags, since nothing can be judged without drive
    // The measured current is one shared value, charged to whichever coil is driven
    for (int i = 0; i < 2; i++) begin
      if (driven[i]) begin
        st_d.fault[i].short_flag = st_q.short_s2[i] || (st_q.meas_s2 > CCP_SHORT_CUR_MA);
        st_d.fault[i].open_flag = (st_q.duty[9:2] > CCP_OPEN_DUTY_MIN) &&
          (st_q.meas_s2 < CCP_OPEN_CUR_MA);
      end
    end
    // Inhibit reaches only the odd high-side coil; a low-side coil has no such setting
    if (mode != CCP_DUAL_HS || !direction_even) begin
      if (open_detect_inhibit && mode != CCP_SINGLE_LS) begin
        st_d.fault[0].open_flag = 1'b0;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset clears ramp, integral and flags so the coil starts undriven
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Outputs straight from flops
  assign coil_pwm = st_q.pwm;
  assign duty = st_q.duty;
  assign ramped_setpoint = st_q.setpoint;
  assign regulation_error = st_q.err;
  assign error_integral = st_q.sum;
  assign coil_fault = st_q.fault;

endmodule

// [tb/ccp_coil_model.sv]
// Purpose: behavioural solenoid coil at the far side of the output group
// Assumes: averaged current tracks duty, one mA per count
// Notes: a short pushes current past the trip level
`timescale 1ns/100ps
module ccp_coil_model
  import ccp_pkg::*;
(
  // Drive from the output group
  input wire logic [1:0] coil_pwm,
  input wire logic [9:0] duty,
  // Fault injection
  input wire logic coil_short,
  input wire logic coil_open,
  // Sensing back
  output logic [15:0] measured_ma,
  output logic [1:0] short_sense
);
  // No inductance modelled, so current responds within the tick
  assign measured_ma = coil_short ? 16'h1000 : coil_open ? 16'h0000 : {6'h00, duty};
  // Comparator only trips while a coil is energised
  assign short_sense = coil_short ? coil_pwm : 2'b00;
endmodule

// [tb/ccp_output_checker.sv]
// Purpose: port-level checks on the coil output group
// Assumes: single clock domain, async high reset
// Notes: settle windows of four cycles cover the input synchronisers
`timescale 1ns/100ps
module ccp_output_checker
  import ccp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Configuration
  input wire ccp_mode_e mode,
  input wire logic output_enable,
  input wire logic direction_even,
  input wire logic companion_onoff_coil,
  input wire logic open_detect_inhibit,
  input wire ccp_limits_s first_coil_limits,
  input wire ccp_tuning_s tuning,
  // Outputs watched
  input wire logic [1:0] coil_pwm,
  input wire logic [9:0] duty,
  input wire logic [15:0] ramped_setpoint,
  input wire logic [15:0] error_integral,
  input wire ccp_fault_s [1:0] coil_fault
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_dis; !output_enable [*4] |-> duty == 10'h000 && !coil_pwm[0]; endproperty
  a_dis: assert property (p_dis) else $error("drive while disabled");
  property p_clr; !output_enable [*4] |-> error_integral == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("integral kept while disabled");
  property p_dir; (mode == CCP_DUAL_HS && $stable(direction_even)) [*4] |-> !coil_pwm[!direction_even]; endproperty
  a_dir: assert property (p_dir) else $error("unselected coil pulsed");
  property p_bang; (mode == CCP_SINGLE_HS && $stable(companion_onoff_coil)) [*4]
    |-> coil_pwm[1] == companion_onoff_coil; endproperty
  a_bang: assert property (p_bang) else $error("companion coil wrong");
  property p_up; tuning.ramp_up == 16'h0001 && ramped_setpoint > $past(ramped_setpoint)
    |-> ramped_setpoint - $past(ramped_setpoint) <= 16'h0023; endproperty
  a_up: assert property (p_up) else $error("rise too steep");
  property p_dn; tuning.ramp_down == 16'h0001 && ramped_setpoint < $past(ramped_setpoint)
    |-> $past(ramped_setpoint) - ramped_setpoint <= 16'h0023; endproperty
  a_dn: assert property (p_dn) else $error("fall too steep");
  property p_ceil; (mode != CCP_DUAL_HS || !direction_even) && ramped_setpoint > $past(ramped_setpoint)
    |-> ramped_setpoint <= first_coil_limits.ceiling_ma; endproperty
  a_ceil: assert property (p_ceil) else $error("setpoint above ceiling");
  property p_inh; (open_detect_inhibit && mode == CCP_SINGLE_HS) [*4] |-> !coil_fault[0].open_flag; endproperty
  a_inh: assert property (p_inh) else $error("open flag not inhibited");
  // Main scenarios reached
  c_pwm: cover property (coil_pwm[0]);
  c_short: cover property (coil_fault[0].short_flag);
  c_ramp: cover property ($changed(ramped_setpoint));
  c_open: cover property (coil_fault[0].open_flag);
endmodule

// [tb/tb_ccp_output.sv]
// Purpose: self-checking bench for the coil output group
// Assumes: one control tick every 25000 cycles
// Notes: only three ticks are run to keep the run short
`timescale 1ns/100ps
module tb_ccp_output;
  import ccp_pkg::*;
  typedef struct packed {ccp_mode_e m; logic d; logic c; logic i; logic v;} ccp_row_s;
  // Mode, direction, companion, checked coil index, expected level
  localparam ccp_row_s ROWS [4] = '{'{CCP_DUAL_HS, 1'b0, 1'b1, 1'b1, 1'b0}, '{CCP_DUAL_HS, 1'b1, 1'b1, 1'b0, 1'b0},
    '{CCP_SINGLE_HS, 1'b0, 1'b1, 1'b1, 1'b1}, '{CCP_SINGLE_HS, 1'b0, 1'b0, 1'b1, 1'b0}};
  logic sys_clk = 1'b0, sys_rst = 1'b1, output_enable = 1'b1, direction_even = 1'b0;
  logic companion_onoff_coil = 1'b0, open_detect_inhibit = 1'b1, coil_short = 1'b0, coil_open = 1'b0;
  ccp_mode_e mode = CCP_SINGLE_HS;
  logic [6:0] target_pct = 7'h64;
  ccp_limits_s first_coil_limits = {16'h0000, 16'h03e8}, second_coil_limits = {16'h0000, 16'h03e8};
  ccp_tuning_s tuning = {16'h0001, 16'h0001, 8'h10, 8'h00};
  logic [15:0] measured_ma, ramped_setpoint, regulation_error, error_integral, prev_sp;
  logic [1:0] short_sense, coil_pwm;
  logic [9:0] duty;
  ccp_fault_s [1:0] coil_fault;
  int n_errors = 0, num_checks = 0;
  ccp_output DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode(mode), .output_enable(output_enable),
    .direction_even(direction_even), .companion_onoff_coil(companion_onoff_coil),
    .open_detect_inhibit(open_detect_inhibit), .target_pct(target_pct), .first_coil_limits(first_coil_limits),
    .second_coil_limits(second_coil_limits), .tuning(tuning), .measured_ma(measured_ma),
    .short_sense(short_sense), .coil_pwm(coil_pwm), .duty(duty), .ramped_setpoint(ramped_setpoint),
    .regulation_error(regulation_error), .error_integral(error_integral), .coil_fault(coil_fault));
  ccp_coil_model u_coil (.coil_pwm(coil_pwm), .duty(duty), .coil_short(coil_short), .coil_open(coil_open),
    .measured_ma(measured_ma), .short_sense(short_sense));
  // 250 MHz clock
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Bounded wait for the next setpoint update; a lost tick ends the run
  task automatic next_tick();
    prev_sp = ramped_setpoint;
    for (int k = 0; k < 26000 && ramped_setpoint === prev_sp; k++) step(1);
    if (ramped_setpoint === prev_sp) begin
      n_errors++;
      $display("ERROR t=%0t no tick", $time);
      tally_and_finish();
    end
  endtask
  initial begin
    step(10);
    sys_rst = 1'b0;
    foreach (ROWS[r]) begin
      mode = ROWS[r].m;
      direction_even = ROWS[r].d;
      companion_onoff_coil = ROWS[r].c;
      step(6);
      repeat (40) begin
        chk({15'h0000, coil_pwm[ROWS[r].i]}, {15'h0000, ROWS[r].v});
        step(1);
      end
    end
    // Ramp up at full rate from zero, coil at rest
    mode = CCP_DUAL_HS;
    direction_even = 1'b0;
    next_tick();
    chk(ramped_setpoint, 16'h0023);
    chk(regulation_error, 16'h0023);
    next_tick();
    chk(ramped_setpoint, 16'h0046);
    coil_short = 1'b1;
    for (int k = 0; k < 3000 && coil_fault[0].short_flag !== 1'b1; k++) step(1);
    chk({15'h0000, coil_fault[0].short_flag}, 16'h0001);
    coil_short = 1'b0;
    step(4);
    chk({15'h0000, coil_fault[0].short_flag}, 16'h0000);
    // Ramp down with the coil open and a stiff P gain: 255 * 35 >> 4 = 557
    coil_open = 1'b1;
    open_detect_inhibit = 1'b0;
    tuning.proportional_gain = 8'hff;
    target_pct = 7'h00;
    next_tick();
    chk(ramped_setpoint, 16'h0023);
    chk(regulation_error, 16'h0023);
    chk({6'h00, duty}, 16'h022d);
    step(2);
    chk({15'h0000, coil_fault[0].open_flag}, 16'h0001);
    open_detect_inhibit = 1'b1;
    step(2);
    chk({15'h0000, coil_fault[0].open_flag}, 16'h0000);
    output_enable = 1'b0;
    step(6);
    chk({6'h00, duty}, 16'h0000);
    chk({14'h0000, coil_pwm}, 16'h0000);
    chk(error_integral, 16'h0000);
    tally_and_finish();
  end
endmodule
bind ccp_output ccp_output_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode(mode),
  .output_enable(output_enable), .direction_even(direction_even), .companion_onoff_coil(companion_onoff_coil),
  .open_detect_inhibit(open_detect_inhibit), .first_coil_limits(first_coil_limits), .tuning(tuning),
  .coil_pwm(coil_pwm), .duty(duty), .ramped_setpoint(ramped_setpoint), .error_integral(error_integral),
  .coil_fault(coil_fault));
